// ==== inc/imo_pkg.sv ====
// Constants for the inertial output data register block.
// Assumes a single 40 MHz core clock and 16-bit register reads.
package imo_pkg;
    // ****************************************
    // Register byte addresses
    // ****************************************
    localparam logic [6:0] ADDR_Y_ACCEL_EXTRA = 7'h14;
    localparam logic [6:0] ADDR_Y_ACCEL_HIGH  = 7'h16;
    localparam logic [6:0] ADDR_Z_ACCEL_EXTRA = 7'h18;
    localparam logic [6:0] ADDR_Z_ACCEL_HIGH  = 7'h1A;
    localparam logic [6:0] ADDR_TEMPERATURE   = 7'h1C;
    localparam logic [6:0] ADDR_ELAPSED_TIME  = 7'h1E;
    localparam logic [6:0] ADDR_UPDATE_COUNT  = 7'h22;
    localparam logic [6:0] ADDR_ANGLE_LOW     = 7'h24;
    localparam logic [6:0] ADDR_ANGLE_HIGH    = 7'h26;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int         SYNC_MODE_LSB    = 2;
    localparam int         SYNC_MODE_MSB    = 4;
    localparam logic [2:0] SYNC_MODE_SCALED = 3'h2;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] WORD_ZERO       = 16'h0000;
    localparam logic [15:0] STAMP_MAX       = 16'hFFFF;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 25000;
    localparam int STAMP_LSB_PS  = 49020000;
    // Nearest-below whole cycle count for one elapsed-time count
    localparam int STAMP_CYCLES  = STAMP_LSB_PS / CLK_PERIOD_PS;
    localparam int NOMINAL_SPS   = 2000;
endpackage

// ==== rtl/imo_output_regs.sv ====
// Output data registers: accel words, temperature, elapsed time,
// update counter and x-axis delta angle integration.
// Assumes samples arrive on the core clock from the sensor pipeline
// and that the sync pin is asynchronous to it.
// Operation
// - Accel high word, signed, 0.25 mg steps
// - Each accel axis has extra-resolution low word
// - Accel high and low form 32-bit value
// - Temperature signed, 0.1 C per count
// - Elapsed time since sync, 49.02 us count
// - Elapsed time valid in scaled sync mode
// - Update loads time of its last sample
// - Update counter zero after power-on, reset command
// - Counter increments per update, wraps at FFFF
// - Trapezoidal sum of current plus previous rate
// - Integration length is decimation setting plus one
// - Internal sample rate nominally 2000 SPS
// - Angle high and low form 32-bit value
// - Angle high word signed, full scale over 2^15
// - Full scale set by product variant
// - X angle low word holds lower half
`timescale 1ns/100ps
`default_nettype none
module imo_output_regs #(
    parameter int ACC_W       = 56,
    parameter int ANGLE_SHIFT = 1
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        reset_command,
    input  wire logic        sample_valid,
    output logic             sample_ready,
    input  wire logic [31:0] gyro_x_rate,
    input  wire logic [31:0] y_accel_sample,
    input  wire logic [31:0] z_accel_sample,
    input  wire logic [15:0] temperature_sample,
    input  wire logic        read_hold,
    input  wire logic [15:0] decimation_setting,
    input  wire logic [15:0] miscellaneous_control,
    input  wire logic        sync_pin,
    input  wire logic        rd_en,
    input  wire logic [6:0]  rd_addr,
    output logic             rd_valid,
    output logic [15:0]      rd_data,
    output logic             data_ready_output
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    if (ACC_W < 50) begin : g_acc_chk
        $error("ACC_W must hold D=65536 sums of 33 bits");
    end
    if (ANGLE_SHIFT < 0 || ANGLE_SHIFT > ACC_W - 32) begin : g_shift_chk
        $error("ANGLE_SHIFT out of range");
    end

    localparam int ENTRY_W = 112;

    function automatic logic signed [ACC_W-1:0] imo_sext(input logic signed [32:0] v);
        imo_sext = ACC_W'(v);
    endfunction

    // ****************************************
    // Two-entry sample buffer
    // ****************************************
    logic [ENTRY_W-1:0] buf_mem [2];
    logic               buf_wr_ptr;
    logic               buf_rd_ptr;
    logic [1:0]         buf_count;
    logic               buf_out_valid;
    logic               drain;
    logic               fill;
    logic [ENTRY_W-1:0] head;

    assign sample_ready  = (buf_count != 2'h2);
    assign buf_out_valid = (buf_count != 2'h0);
    // Held reads stall the drain so a host burst sees one sample set
    assign drain         = buf_out_valid && !read_hold;
    assign fill          = sample_valid && sample_ready;
    assign head          = buf_mem[buf_rd_ptr];

    always_ff @(posedge core_clk) begin
        if (fill) begin
            buf_mem[buf_wr_ptr] <= {gyro_x_rate, y_accel_sample, z_accel_sample,
                                    temperature_sample};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            buf_wr_ptr <= 1'b0;
            buf_rd_ptr <= 1'b0;
            buf_count  <= 2'h0;
        end else begin
            if (fill) begin
                buf_wr_ptr <= ~buf_wr_ptr;
            end
            if (drain) begin
                buf_rd_ptr <= ~buf_rd_ptr;
            end
            buf_count <= buf_count + 2'(fill) - 2'(drain);
        end
    end

    // ****************************************
    // Sync pin and elapsed-time counter
    // ****************************************
    logic        sync_meta;
    logic        sync_s2;
    logic        sync_s3;
    logic        sync_edge;
    logic [11:0] tick_div;
    logic [15:0] stamp_cnt;
    logic        scaled_mode;

    assign sync_edge   = sync_s2 && !sync_s3;
    assign scaled_mode = (miscellaneous_control[imo_pkg::SYNC_MODE_MSB:imo_pkg::SYNC_MODE_LSB]
                          == imo_pkg::SYNC_MODE_SCALED);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_meta <= 1'b0;
            sync_s2   <= 1'b0;
            sync_s3   <= 1'b0;
        end else begin
            sync_meta <= sync_pin;
            sync_s2   <= sync_meta;
            sync_s3   <= sync_s2;
        end
    end

    // Saturates rather than wraps, so a lost sync never looks recent
    always_ff @(posedge core_clk) begin
        if (rst || sync_edge) begin
            tick_div  <= 12'h000;
            stamp_cnt <= imo_pkg::WORD_ZERO;
        end else if (tick_div == 12'(imo_pkg::STAMP_CYCLES - 1)) begin
            tick_div <= 12'h000;
            if (stamp_cnt != imo_pkg::STAMP_MAX) begin
                stamp_cnt <= stamp_cnt + 16'h0001;
            end
        end else begin
            tick_div <= tick_div + 12'h001;
        end
    end

    // ****************************************
    // Delta angle integration
    // ****************************************
    logic signed [31:0]      cur_rate;
    logic signed [31:0]      prev_rate;
    logic signed [32:0]      pair_sum;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] next_acc;
    logic signed [ACC_W-1:0] scaled;
    logic [15:0]             dec_cnt;
    logic                    publish;

    assign cur_rate = head[111:80];
    assign pair_sum = 33'(cur_rate) + 33'(prev_rate);
    assign next_acc = ((dec_cnt == 16'h0000) ? '0 : acc) + imo_sext(pair_sum);
    // The 1/fs factor is folded into the rate units; the shift is the halving
    assign scaled   = next_acc >>> ANGLE_SHIFT;
    assign publish  = drain && (dec_cnt == decimation_setting);

    always_ff @(posedge core_clk) begin
        if (rst || reset_command) begin
            prev_rate <= '0;
            acc       <= '0;
            dec_cnt   <= 16'h0000;
        end else if (drain) begin
            prev_rate <= cur_rate;
            acc       <= next_acc;
            dec_cnt   <= publish ? 16'h0000 : dec_cnt + 16'h0001;
        end
    end

    // ****************************************
    // Output registers
    // ****************************************
    logic [31:0] y_accel_word;
    logic [31:0] z_accel_word;
    logic [15:0] temperature_reading;
    logic [15:0] sync_elapsed_time;
    logic [15:0] update_counter;
    logic [31:0] x_angle_delta;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            y_accel_word        <= '0;
            z_accel_word        <= '0;
            temperature_reading <= imo_pkg::WORD_ZERO;
            sync_elapsed_time   <= imo_pkg::WORD_ZERO;
            x_angle_delta       <= '0;
        end else if (publish) begin
            y_accel_word        <= head[79:48];
            z_accel_word        <= head[47:16];
            temperature_reading <= head[15:0];
            sync_elapsed_time   <= scaled_mode ? stamp_cnt : imo_pkg::WORD_ZERO;
            x_angle_delta       <= scaled[31:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || reset_command) begin
            update_counter <= imo_pkg::COUNT_RESET;
        end else if (publish) begin
            update_counter <= update_counter + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_ready_output <= 1'b0;
        end else begin
            data_ready_output <= publish;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    logic [15:0] next_rd_data;

    always_comb begin
        case ({rd_addr[6:1], 1'b0})
            imo_pkg::ADDR_Y_ACCEL_EXTRA: next_rd_data = y_accel_word[15:0];
            imo_pkg::ADDR_Y_ACCEL_HIGH:  next_rd_data = y_accel_word[31:16];
            imo_pkg::ADDR_Z_ACCEL_EXTRA: next_rd_data = z_accel_word[15:0];
            imo_pkg::ADDR_Z_ACCEL_HIGH:  next_rd_data = z_accel_word[31:16];
            imo_pkg::ADDR_TEMPERATURE:   next_rd_data = temperature_reading;
            imo_pkg::ADDR_ELAPSED_TIME:  next_rd_data = sync_elapsed_time;
            imo_pkg::ADDR_UPDATE_COUNT:  next_rd_data = update_counter;
            imo_pkg::ADDR_ANGLE_LOW:     next_rd_data = x_angle_delta[15:0];
            imo_pkg::ADDR_ANGLE_HIGH:    next_rd_data = x_angle_delta[31:16];
            default:                     next_rd_data = imo_pkg::WORD_ZERO;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= imo_pkg::WORD_ZERO;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    logic [16:0] drains_seen;

    always_ff @(posedge core_clk) begin
        if (rst || reset_command) begin
            drains_seen <= 17'h00000;
        end else if (publish) begin
            drains_seen <= 17'h00000;
        end else if (drain) begin
            drains_seen <= drains_seen + 17'h00001;
        end
    end

    counter_reset_a: assert property (@(posedge core_clk)
        (rst || reset_command) |=> (update_counter == imo_pkg::COUNT_RESET))
        else $error("update counter not cleared by reset");

    counter_step_a: assert property (@(posedge core_clk) disable iff (rst)
        (publish && !reset_command) |=> (update_counter == $past(update_counter) + 16'h0001))
        else $error("update counter did not step by one");

    coherent_set_a: assert property (@(posedge core_clk) disable iff (rst)
        ($changed(x_angle_delta) || $changed(z_accel_word) || $changed(update_counter))
        |-> ($past(publish) || $past(reset_command)))
        else $error("output register changed outside an update");

    integ_length_a: assert property (@(posedge core_clk) disable iff (rst || reset_command)
        publish |-> (drains_seen == {1'b0, decimation_setting}))
        else $error("integration length not decimation plus one");

    stamp_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        (publish && !scaled_mode) |=> (sync_elapsed_time == imo_pkg::WORD_ZERO))
        else $error("elapsed time loaded outside scaled mode");

    stamp_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        (sync_s2 && !sync_s3) |=> (stamp_cnt == imo_pkg::WORD_ZERO) [*2])
        else $error("elapsed time not restarted by sync edge");

    temp_load_a: assert property (@(posedge core_clk) disable iff (rst)
        publish |=> (temperature_reading == $past(head[15:0])))
        else $error("temperature not loaded with sample");

    angle_low_a: assert property (@(posedge core_clk) disable iff (rst)
        (rd_en && rd_addr == imo_pkg::ADDR_ANGLE_LOW)
        |=> (rd_valid && rd_data == $past(x_angle_delta[15:0])))
        else $error("angle low word read wrong");

    accel_high_a: assert property (@(posedge core_clk) disable iff (rst)
        (rd_en && rd_addr == imo_pkg::ADDR_Z_ACCEL_HIGH)
        |=> (rd_data == $past(z_accel_word[31:16])))
        else $error("accel high word read wrong");

    trapezoid_a: assert property (@(posedge core_clk) disable iff (rst || reset_command)
        (drain && dec_cnt == 16'h0000)
        |=> (acc == ACC_W'($past(pair_sum))))
        else $error("first trapezoid term wrong");
endmodule
`default_nettype wire

// ==== verif/imo_output_regs_tb_top.sv ====
// Self-checking bench for the output data registers.
// Assumes the sample source model in imo_sample_src.sv.
`timescale 1ns/100ps
`default_nettype none
module imo_output_regs_tb_top;
    logic        core_clk, rst, reset_command, sample_valid, sample_ready, read_hold;
    logic        sync_pin, rd_en, rd_valid, data_ready_output, ok;
    logic [31:0] gyro_x_rate, y_accel_sample, z_accel_sample;
    logic [15:0] temperature_sample, decimation_setting, miscellaneous_control, rd_data, d;
    logic [6:0]  rd_addr;
    logic signed [63:0] acc, prev;
    logic [15:0] exp_w[10];
    integer      seed = 32'h2304;
    int          bad_count, checks_done, nsmp;

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    imo_output_regs #(.ACC_W(56), .ANGLE_SHIFT(1)) u_dut (.core_clk(core_clk), .rst(rst),
        .reset_command(reset_command), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .gyro_x_rate(gyro_x_rate),
        .y_accel_sample(y_accel_sample), .z_accel_sample(z_accel_sample),
        .temperature_sample(temperature_sample), .read_hold(read_hold),
        .decimation_setting(decimation_setting), .miscellaneous_control(miscellaneous_control),
        .sync_pin(sync_pin), .rd_en(rd_en), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .data_ready_output(data_ready_output));
    imo_sample_src u_src (.core_clk(core_clk), .sample_ready(sample_ready),
        .sample_valid(sample_valid), .gyro_x_rate(gyro_x_rate),
        .y_accel_sample(y_accel_sample), .z_accel_sample(z_accel_sample),
        .temperature_sample(temperature_sample));

    // ****************************************
    // Bench tasks
    // ****************************************
    // Halving models the one-over-two factor; no saturation, low 32 bits kept
    function automatic logic [31:0] angle_of(input logic signed [63:0] a);
        angle_of = 32'(a >>> 1);
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic stop_on(input logic c);
        if (!c) begin
            bad_count++;
            $display("MISMATCH wait expected 1 seen 0");
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] v);
        @(posedge core_clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(negedge core_clk);
        chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
        v = rd_data;
    endtask

    task automatic check_all(input string nm);
        for (int i = 0; i < 10; i++) begin
            rd(7'(8'h14 + 2 * i), d);
            chk($sformatf("%s_%h", nm, 8'h14 + 2 * i), exp_w[i], d);
        end
        $display("test %s done", nm);
    endtask

    task automatic wait_dr();
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (data_ready_output !== 1'b1 && n < 500);
        stop_on(data_ready_output === 1'b1);
    endtask

    task automatic send(input logic [31:0] r, input int gap, input logic last);
        logic [31:0] y, z, a;
        logic [15:0] t;
        y = $random(seed);
        z = $random(seed);
        t = 16'($random(seed));
        u_src.push(r, y, z, t, gap, last, ok);
        stop_on(ok);
        acc = acc + $signed(r) + prev;
        prev = $signed(r);
        nsmp++;
        if (nsmp == int'(decimation_setting) + 1) begin
            a = angle_of(acc);
            exp_w[0] = y[15:0];
            exp_w[1] = y[31:16];
            exp_w[2] = z[15:0];
            exp_w[3] = z[31:16];
            exp_w[4] = t;
            exp_w[7] = exp_w[7] + 16'h0001;
            exp_w[8] = a[15:0];
            exp_w[9] = a[31:16];
            acc = 0;
            nsmp = 0;
        end
    endtask

    task automatic burst(input int n, input logic [31:0] r0);
        for (int k = 0; k < n; k++) begin
            send(k == 0 ? r0 : $random(seed), k == 0 ? 1 + $unsigned($random(seed)) % 2 : 0,
                 k == n - 1);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rst, reset_command, read_hold, sync_pin, rd_en} = 5'h10;
        {rd_addr, decimation_setting, miscellaneous_control} = '0;
        {acc, prev, nsmp, bad_count, checks_done} = '0;
        exp_w = '{default: 16'h0000};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        check_all("reset");
        for (int n = 0; n < 4; n++) begin
            @(posedge core_clk);
            decimation_setting <= 16'(n);
            burst(n + 1, n[0] ? 32'h8000_0000 : 32'h7FFF_FFFF);
            wait_dr();
            check_all($sformatf("decim%0d", n));
        end
        // Reads stay allowed while held; the counter must not move meanwhile
        @(posedge core_clk);
        decimation_setting <= 16'h0000;
        read_hold <= 1'b1;
        burst(1, $random(seed));
        burst(1, $random(seed));
        @(negedge core_clk);
        chk("sample_ready_full", 16'h0000, {15'h0000, sample_ready});
        rd(7'h22, d);
        chk("held_counter", exp_w[7] - 16'h0002, d);
        @(posedge core_clk);
        read_hold <= 1'b0;
        wait_dr();
        wait_dr();
        check_all("stall");
        @(posedge core_clk);
        miscellaneous_control <= 16'h0008;
        sync_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        sync_pin <= 1'b0;
        repeat (2 * 1960 + 600) @(posedge core_clk);
        exp_w[5] = 16'h0002;
        burst(1, $random(seed));
        wait_dr();
        check_all("scaled");
        @(posedge core_clk);
        miscellaneous_control <= 16'h0000;
        exp_w[5] = 16'h0000;
        burst(1, $random(seed));
        wait_dr();
        check_all("unscaled");
        @(posedge core_clk);
        reset_command <= 1'b1;
        @(posedge core_clk);
        reset_command <= 1'b0;
        rd(7'h22, d);
        chk("counter_cleared", 16'h0000, d);
        exp_w[7] = 16'h0000;
        // The reset command also empties the rate history of the integrator
        prev = 0;
        burst(1, $random(seed));
        wait_dr();
        rd(7'h22, d);
        chk("counter_restart", 16'h0001, d);
        check_all("restart");
        $display("test reset_command done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== verif/imo_sample_src.sv ====
// Sample source model: offers sensor sample sets on the valid/ready side.
// Assumes the bench calls push() from one process, after clock edges.
`timescale 1ns/100ps
`default_nettype none
module imo_sample_src (
    input  wire logic        core_clk,
    input  wire logic        sample_ready,
    output logic             sample_valid,
    output logic [31:0]      gyro_x_rate,
    output logic [31:0]      y_accel_sample,
    output logic [31:0]      z_accel_sample,
    output logic [15:0]      temperature_sample
);
    initial begin
        sample_valid = 1'b0;
        gyro_x_rate = 32'h0000_0000;
        y_accel_sample = 32'h0000_0000;
        z_accel_sample = 32'h0000_0000;
        temperature_sample = 16'h0000;
    end

    // Valid stays up between sets of a burst so that no edge sees two drives;
    // after the last set the data lines flip, so stale words never look fresh
    task automatic push(input logic [31:0] r, input logic [31:0] y, input logic [31:0] z,
                        input logic [15:0] t, input int gap, input logic last,
                        output logic taken);
        int n;
        n = 0;
        taken = 1'b0;
        repeat (gap) @(posedge core_clk);
        sample_valid <= 1'b1;
        gyro_x_rate <= r;
        y_accel_sample <= y;
        z_accel_sample <= z;
        temperature_sample <= t;
        while (!taken && n < 200) begin
            @(negedge core_clk);
            taken = (sample_ready === 1'b1);
            @(posedge core_clk);
            n++;
        end
        if (last) begin
            sample_valid <= 1'b0;
            gyro_x_rate <= ~r;
            y_accel_sample <= ~y;
            z_accel_sample <= ~z;
            temperature_sample <= ~t;
        end
    endtask
endmodule
`default_nettype wire
